// *** inc/bmf_params.svh ***
// How it works
// - Double rate both sides, x40: words taken rising then falling, read out same order.
// - Single rate both sides, x40: one word per write rise, one per read rise.
// - Single write, double read, x20 out: upper half on read rise, lower on fall.
// - Double write, x20 in: rise half fills upper, fall half lower, one read rise.
// - Double write, single read, x40: two words per write cycle, one per read rise.
// - Single rate both, x20 out: upper half first read rise, lower half next.
// - Double rate both, x20 out: halves of each word on successive read edges.
// - Single write, double read, x10 out: four bytes, MSB first, alternating edges.
// - Double write, single read, x20 out: four halves on four read rises.
// - Single rate both, x10 out: four bytes MSB first, one per read rise.
// - Double rate both, x10 out: eight bytes per write cycle on alternating edges.
// - Double write, single read, x10 out: eight bytes on eight read rises.
// - Unused upper output lines stay zero for x20 and x10 output widths.
`ifndef BMF_PARAMS_SVH
`define BMF_PARAMS_SVH

// Register byte offsets
`define BMF_ADDR_W 4
`define BMF_OFF_CFG 4'h0
`define BMF_OFF_STATUS 4'h4
`define BMF_OFF_CLEAR 4'h8

// Configuration field positions and reset value
`define BMF_CFG_WR_RATE 0
`define BMF_CFG_RD_RATE 1
`define BMF_CFG_BM 2
`define BMF_CFG_IN_SIZE 3
`define BMF_CFG_OUT_SIZE 4
`define BMF_CFG_RST 5'h00

// Status field positions
`define BMF_ST_LEVEL_LSB 0
`define BMF_ST_OVF 8
`define BMF_ST_UDR 9
`define BMF_ST_ACT_LSB 16

// AXI responses
`define BMF_RESP_OKAY 2'h0
`define BMF_RESP_SLVERR 2'h2

// Data path shape
`define BMF_DATA_W 40
`define BMF_FIFO_DEPTH 16
`define BMF_LEVEL_W 5

`endif

// *** inc/bmf_pkg.sv ***
package bmf_pkg;
`include "bmf_params.svh"

	// Static port configuration; high rate select means double rate
	typedef struct packed {
		logic out_port_size_sel;
		logic in_port_size_sel;
		logic bus_matching_on;
		logic rd_single_rate_sel;
		logic wr_single_rate_sel;
	} bmf_cfg_s;

	typedef logic [`BMF_DATA_W-1:0] bmf_word_t;

	// Index of last output segment of a word: 0, 1 or 3
	function automatic logic [1:0] bmf_out_last(input bmf_cfg_s c);
		logic [1:0] r;
		r = 2'h0;
		if (c.bus_matching_on && !c.in_port_size_sel) begin
			r = c.out_port_size_sel ? 2'h3 : 2'h1;
		end
		return r;
	endfunction

	// Index of last input segment of a word: 0, 1 or 3
	function automatic logic [1:0] bmf_in_last(input bmf_cfg_s c);
		logic [1:0] r;
		r = 2'h0;
		if (c.bus_matching_on && c.in_port_size_sel) begin
			r = c.out_port_size_sel ? 2'h3 : 2'h1;
		end
		return r;
	endfunction
endpackage

// *** inc/bmf_stream_if.sv ***
`timescale 1ns/1ns
interface bmf_stream_if #(
	parameter int W = 40,
	parameter int LW = 5
);
	logic clear;
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	logic [LW-1:0] level;

	modport fifo (
		input clear, in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data, level
	);
	modport user (
		output clear, in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data, level
	);
endinterface

// *** rtl/bmf_fifo.sv ***
`timescale 1ns/1ns
module bmf_fifo #(
	parameter int W = 40,
	parameter int D = 16,
	parameter int LW = 5
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Stream
	bmf_stream_if.fifo st
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [LW-1:0] count;
	} bmf_fifo_s;

	bmf_fifo_s s_reg;
	bmf_fifo_s s_next;
	logic [W-1:0] mem [D];
	logic push;
	logic pop;

	// Flags come from the count only, so full and empty are exact
	assign st.in_ready = (s_reg.count != LW'(D));
	assign st.out_valid = (s_reg.count != '0);
	assign st.out_data = mem[s_reg.rd_ptr];
	assign st.level = s_reg.count;
	assign push = st.in_valid && st.in_ready && !st.clear;
	assign pop = st.out_valid && st.out_ready && !st.clear;

	// Pointer and count update
	always_comb begin
		s_next = s_reg;
		if (st.clear) begin
			s_next = '0;
		end else begin
			if (push) begin
				s_next.wr_ptr = AW'(s_reg.wr_ptr + 1'b1);
			end
			if (pop) begin
				s_next.rd_ptr = AW'(s_reg.rd_ptr + 1'b1);
			end
			if (push && !pop) begin
				s_next.count = LW'(s_reg.count + 1'b1);
			end else if (pop && !push) begin
				s_next.count = LW'(s_reg.count - 1'b1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// Storage needs no reset; empty words are never read
	always_ff @(posedge aclk) begin
		if (ce && push) begin
			mem[s_reg.wr_ptr] <= st.in_data;
		end
	end
endmodule

// *** rtl/bmf_top.sv ***
`timescale 1ns/1ns
`include "bmf_params.svh"
module bmf_top (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`BMF_ADDR_W-1:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [`BMF_ADDR_W-1:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Reset pin from the controlling logic
	input wire logic master_reset_n,
	// Write port pins
	input wire logic wr_clk,
	input wire logic wr_en,
	input wire logic [`BMF_DATA_W-1:0] wr_data,
	output logic wr_ready,
	// Read port pins
	input wire logic rd_clk,
	input wire logic rd_en,
	output logic [`BMF_DATA_W-1:0] rd_data,
	output logic rd_valid
);
	import bmf_pkg::*;

	typedef struct packed {
		// Pin synchronisers and edge history
		logic [1:0] wclk_sync;
		logic [1:0] rclk_sync;
		logic [1:0] mrst_sync;
		logic [1:0] wen_sync;
		logic [1:0] ren_sync;
		bmf_word_t wd_s1;
		bmf_word_t wd_s2;
		logic wclk_last;
		logic rclk_last;
		// Configuration
		bmf_cfg_s cfg_reg;
		bmf_cfg_s cfg_act;
		// Write packing
		bmf_word_t pack_acc;
		logic [1:0] pack_cnt;
		logic push_valid;
		bmf_word_t push_data;
		// Read unpacking
		bmf_word_t cur;
		logic [1:0] seg_left;
		bmf_word_t rd_data;
		logic rd_valid;
		logic wr_ready;
		logic ovf;
		logic udr;
		// Bus slave
		logic awready;
		logic wready;
		logic arready;
		logic aw_got;
		logic [`BMF_ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bmf_state_s;

	bmf_state_s s_reg;
	bmf_state_s s_next;
	bmf_stream_if #(.W(`BMF_DATA_W), .LW(`BMF_LEVEL_W)) st ();

	bmf_fifo #(
		.W(`BMF_DATA_W),
		.D(`BMF_FIFO_DEPTH),
		.LW(`BMF_LEVEL_W)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.st(st)
	);

	logic in_reset;
	logic w_rise;
	logic w_fall;
	logic w_edge;
	logic r_rise;
	logic r_fall;
	logic r_edge;
	logic need_word;

	// Edges are seen on the second synchroniser stage only
	assign in_reset = !s_reg.mrst_sync[1];
	assign w_rise = s_reg.wclk_sync[1] && !s_reg.wclk_last;
	assign w_fall = !s_reg.wclk_sync[1] && s_reg.wclk_last;
	assign w_edge = !in_reset && s_reg.wen_sync[1]
		&& (w_rise || (w_fall && s_reg.cfg_act.wr_single_rate_sel));
	assign r_rise = s_reg.rclk_sync[1] && !s_reg.rclk_last;
	assign r_fall = !s_reg.rclk_sync[1] && s_reg.rclk_last;
	assign r_edge = !in_reset && s_reg.ren_sync[1]
		&& (r_rise || (r_fall && s_reg.cfg_act.rd_single_rate_sel));
	assign need_word = (s_reg.seg_left == 2'h0);

	// FIFO hookup; pop only when a read edge finds the holder spent
	assign st.clear = in_reset;
	assign st.in_valid = s_reg.push_valid;
	assign st.in_data = s_reg.push_data;
	assign st.out_ready = r_edge && need_word;

	// Next state for pins, bus, packing and unpacking
	always_comb begin
		bmf_word_t src;
		bmf_word_t acc;
		logic [31:0] rword;
		src = '0;
		acc = '0;
		rword = '0;
		s_next = s_reg;

		// Synchroniser chains
		s_next.wclk_sync = {s_reg.wclk_sync[0], wr_clk};
		s_next.rclk_sync = {s_reg.rclk_sync[0], rd_clk};
		s_next.mrst_sync = {s_reg.mrst_sync[0], master_reset_n};
		s_next.wen_sync = {s_reg.wen_sync[0], wr_en};
		s_next.ren_sync = {s_reg.ren_sync[0], rd_en};
		s_next.wd_s1 = wr_data;
		s_next.wd_s2 = s_reg.wd_s1;
		s_next.wclk_last = s_reg.wclk_sync[1];
		s_next.rclk_last = s_reg.rclk_sync[1];
		s_next.wr_ready = st.in_ready;

		// Write channels, taken in either order
		if (s_axi_awvalid && s_reg.awready) begin
			s_next.aw_got = 1'b1;
			s_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_reg.wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		// Commit once address and data are both held
		if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = `BMF_RESP_OKAY;
			case (s_reg.aw_addr)
				`BMF_OFF_CFG: begin
					if (s_reg.wstrb[0]) begin
						s_next.cfg_reg.wr_single_rate_sel = s_reg.wdata[`BMF_CFG_WR_RATE];
						s_next.cfg_reg.rd_single_rate_sel = s_reg.wdata[`BMF_CFG_RD_RATE];
						s_next.cfg_reg.bus_matching_on = s_reg.wdata[`BMF_CFG_BM];
						s_next.cfg_reg.in_port_size_sel = s_reg.wdata[`BMF_CFG_IN_SIZE];
						s_next.cfg_reg.out_port_size_sel = s_reg.wdata[`BMF_CFG_OUT_SIZE];
					end
				end
				`BMF_OFF_CLEAR: begin
					// Clear first; a hardware set later in this block wins
					if (s_reg.wstrb[1] && s_reg.wdata[`BMF_ST_OVF]) begin
						s_next.ovf = 1'b0;
					end
					if (s_reg.wstrb[1] && s_reg.wdata[`BMF_ST_UDR]) begin
						s_next.udr = 1'b0;
					end
				end
				`BMF_OFF_STATUS: begin
				end
				default: begin
					s_next.bresp = `BMF_RESP_SLVERR;
				end
			endcase
		end

		// Read channel
		if (s_axi_rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_reg.arready) begin
			s_next.rvalid = 1'b1;
			s_next.rresp = `BMF_RESP_OKAY;
			case (s_axi_araddr)
				`BMF_OFF_CFG: begin
					rword[4:0] = s_reg.cfg_reg;
				end
				`BMF_OFF_STATUS: begin
					rword[`BMF_ST_LEVEL_LSB +: `BMF_LEVEL_W] = st.level;
					rword[`BMF_ST_OVF] = s_reg.ovf;
					rword[`BMF_ST_UDR] = s_reg.udr;
					rword[`BMF_ST_ACT_LSB +: 5] = s_reg.cfg_act;
				end
				`BMF_OFF_CLEAR: begin
				end
				default: begin
					s_next.rresp = `BMF_RESP_SLVERR;
				end
			endcase
			s_next.rdata = rword;
		end

		// Config only follows software while master reset is held
		if (in_reset) begin
			s_next.cfg_act = s_reg.cfg_reg;
			s_next.pack_cnt = 2'h0;
			s_next.pack_acc = '0;
			s_next.push_valid = 1'b0;
			s_next.seg_left = 2'h0;
			s_next.rd_valid = 1'b0;
		end

		// Write side: a pending word leaves when the FIFO takes it
		if (s_reg.push_valid && st.in_ready) begin
			s_next.push_valid = 1'b0;
		end
		if (w_edge) begin
			if (s_reg.cfg_act.out_port_size_sel) begin
				acc = {s_reg.pack_acc[29:0], s_reg.wd_s2[9:0]};
			end else begin
				acc = {s_reg.pack_acc[19:0], s_reg.wd_s2[19:0]};
			end
			if (bmf_in_last(s_reg.cfg_act) == 2'h0) begin
				acc = s_reg.wd_s2;
			end
			s_next.pack_acc = acc;
			if (s_reg.pack_cnt == bmf_in_last(s_reg.cfg_act)) begin
				s_next.pack_cnt = 2'h0;
				// A full FIFO loses the older pending word
				if (s_reg.push_valid && !st.in_ready) begin
					s_next.ovf = 1'b1;
				end
				s_next.push_valid = 1'b1;
				s_next.push_data = acc;
			end else begin
				s_next.pack_cnt = 2'(s_reg.pack_cnt + 1'b1);
			end
		end

		// Read side: most significant segment first on each read edge
		if (r_edge) begin
			if (need_word && !st.out_valid) begin
				s_next.rd_valid = 1'b0;
				s_next.udr = 1'b1;
			end else begin
				src = need_word ? st.out_data : s_reg.cur;
				s_next.rd_valid = 1'b1;
				s_next.seg_left = need_word ? bmf_out_last(s_reg.cfg_act)
					: 2'(s_reg.seg_left - 1'b1);
				if (bmf_out_last(s_reg.cfg_act) == 2'h0) begin
					s_next.rd_data = src;
				end else if (s_reg.cfg_act.out_port_size_sel) begin
					s_next.rd_data = {30'h0, src[39:30]};
					s_next.cur = {src[29:0], 10'h0};
				end else begin
					s_next.rd_data = {20'h0, src[39:20]};
					s_next.cur = {src[19:0], 20'h0};
				end
			end
		end

		// Ready flags settle one cycle ahead of the next offer
		s_next.awready = !s_next.aw_got && !s_next.bvalid;
		s_next.wready = !s_next.w_got && !s_next.bvalid;
		s_next.arready = !s_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.cfg_reg <= `BMF_CFG_RST;
			s_reg.cfg_act <= `BMF_CFG_RST;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// Every output straight from the state register
	assign s_axi_awready = s_reg.awready;
	assign s_axi_wready = s_reg.wready;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = s_reg.arready;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign wr_ready = s_reg.wr_ready;
	assign rd_data = s_reg.rd_data;
	assign rd_valid = s_reg.rd_valid;
endmodule

// *** testbench/bmf_chk.sv ***
`timescale 1ns/1ns
`include "bmf_params.svh"
module bmf_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Link pins
	input wire logic master_reset_n,
	input wire logic rd_clk,
	input wire logic [`BMF_DATA_W-1:0] rd_data,
	input wire logic rd_valid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Address and data taken at one edge
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	// Read pin quiet long enough for its sync pipe to drain
	sequence s_rd_quiet;
		(master_reset_n && $stable(rd_clk))[*6];
	endsequence

	a_b_latency: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after the take");
	a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response outlived its handshake");
	a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channels open while response pending");
	a_w_reopen: assert property ($fell(s_axi_bvalid) |=> s_axi_awready && s_axi_wready)
		else $error("write channels not reopened after response");
	a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after the take");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address open while data pending");
	// Sync pipe is two deep, so five low samples must have cleared it
	a_mr_flush: assert property (!master_reset_n[*5] |-> !rd_valid)
		else $error("read valid survived master reset");
	a_rd_hold: assert property (s_rd_quiet |-> $stable(rd_data) && $stable(rd_valid))
		else $error("read outputs moved without a read edge");
endmodule

bind bmf_top bmf_chk u_bmf_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.master_reset_n, .rd_clk, .rd_data, .rd_valid);

// *** testbench/bmf_host.sv ***
`timescale 1ns/1ns
module bmf_host (
	// Write port
	output logic wr_clk,
	output logic wr_en,
	output bmf_pkg::bmf_word_t wr_data,
	// Read port
	output logic rd_clk,
	output logic rd_en,
	input bmf_pkg::bmf_word_t rd_data,
	input wire logic rd_valid
);
	import bmf_pkg::*;

	// Link clocks idle low between frames
	initial begin
		wr_clk = 1'b0;
		wr_en = 1'b0;
		wr_data = '0;
		rd_clk = 1'b0;
		rd_en = 1'b0;
	end

	// Data centred on each edge so the sync pipe never sees it move
	task automatic wr_edge(input bmf_word_t d);
		wr_en = 1'b1;
		wr_data = d;
		#31;
		wr_clk = ~wr_clk;
		#(wr_clk ? 31 : 32);
	endtask

	// Clock stands still; stale data shows its inverse
	task automatic wr_stop();
		wr_en = 1'b0;
		wr_data = ~wr_data;
	endtask

	// One read edge, sampled once the outputs have settled
	task automatic rd_edge(output bmf_word_t q, output logic v);
		rd_en = 1'b1;
		rd_clk = ~rd_clk;
		#(rd_clk ? 62 : 63);
		q = rd_data;
		v = rd_valid;
	endtask
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`include "bmf_params.svh"
module tb;
	import bmf_pkg::*;
	logic aclk, aresetn, ce, master_reset_n;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [`BMF_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic wr_clk, wr_en, wr_ready, rd_clk, rd_en, rd_valid;
	bmf_word_t wr_data, rd_data;
	int error_cnt, tests_run, seed;
	bmf_word_t exp_q[$];
	// Mode bits: out size, in size, bus matching, read rate, write rate
	logic [4:0] modes[12] = '{5'h03, 5'h00, 5'h06, 5'h0D, 5'h01, 5'h04, 5'h07, 5'h16, 5'h05,
		5'h14, 5'h17, 5'h15};

	bmf_top u_bmf_top (.*);
	bmf_host u_bmf_host (.*);

	// System clock
	always #4 aclk = ~aclk;

	task automatic check(input string what, input bmf_word_t seen, input bmf_word_t exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Address and data offered together, each released once taken
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		// A response that never came is a mismatch, not a silent pass
		if (s_axi_bvalid !== 1'b1) error_cnt++;
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		if (s_axi_rvalid !== 1'b1) error_cnt++;
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	// Fill to full, drain to empty, then one more read clock cycle (two read edges) on nothing
	task automatic run_mode(input logic [4:0] c);
		bmf_word_t w, q, mi, mo;
		logic v;
		logic [31:0] d;
		logic [1:0] r;
		int ni, no, iw, ow;
		master_reset_n <= 1'b0;
		axi_wr(`BMF_OFF_CFG, {27'h0, c}, r);
		check("bresp cfg", r, `BMF_RESP_OKAY);
		repeat (4) @(posedge aclk);
		master_reset_n <= 1'b1;
		repeat (4) @(posedge aclk);
		check("wr_ready idle", wr_ready, 1);
		ni = (c[2] && c[3]) ? (c[4] ? 4 : 2) : 1;
		no = (c[2] && !c[3]) ? (c[4] ? 4 : 2) : 1;
		iw = 40 / ni;
		ow = 40 / no;
		mi = (40'h1 << iw) - 1;
		mo = (40'h1 << ow) - 1;
		repeat (16) begin
			w = 40'({$random(seed), $random(seed)});
			for (int k = 0; k < no; k++) exp_q.push_back((w >> (40 - (k + 1) * ow)) & mo);
			// Unused upper input lines carry noise on purpose
			for (int k = 0; k < ni; k++) begin
				q = (w >> (40 - (k + 1) * iw)) & mi | (40'($random(seed)) & ~mi);
				u_bmf_host.wr_edge(q);
				if (!c[0]) u_bmf_host.wr_edge(~q);
			end
		end
		u_bmf_host.wr_stop();
		repeat (6) @(posedge aclk);
		check("wr_ready", wr_ready, 0);
		while (exp_q.size() > 0) begin
			repeat (c[1] ? 1 : 2) u_bmf_host.rd_edge(q, v);
			check("rd_valid", v, 1);
			w = exp_q.pop_front();
			check("rd_data", q & mo, w);
			check("rd_upper", q & ~mo, 0);
		end
		repeat (2) u_bmf_host.rd_edge(q, v);
		check("underrun", v, 0);
		axi_rd(`BMF_OFF_STATUS, d, r);
		check("status", d, {11'h0, c, 16'h0200});
		check("rresp status", r, `BMF_RESP_OKAY);
		axi_wr(`BMF_OFF_CLEAR, 32'h0000_0200, r);
		axi_rd(`BMF_OFF_STATUS, d, r);
		check("status cleared", d, {11'h0, c, 16'h0000});
	endtask

	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		aclk = 1'b0;
		aresetn = 1'b0;
		ce = 1'b1;
		master_reset_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		error_cnt = 0;
		tests_run = 0;
		seed = 32'hCBF6C60B;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(`BMF_OFF_CFG, d, r);
		check("cfg reset", d, `BMF_CFG_RST);
		foreach (modes[i]) run_mode(modes[i]);
		// Unmapped offset answers with an error
		axi_wr(4'hC, 32'hFFFF_FFFF, r);
		check("bresp", r, `BMF_RESP_SLVERR);
		axi_rd(4'hC, d, r);
		check("rresp", r, `BMF_RESP_SLVERR);
		end_of_test();
	end

	// Watchdog, well past the expected run length
	initial begin
		#400000;
		error_cnt++;
		end_of_test();
	end
endmodule
